// ### thl_pkg.sv
/*
 * Constants, state types and carrier structs for the tape record loader.
 * Assumes one 250 MHz clock and a reader that answers each step with a sprocket strobe.
 */
// Overview of operation
// - A colon starts a record; characters before it are ignored.
// - Frames one and two give the data byte count, high digit first.
// - Frames three to six give the load address; later bytes go to ascending addresses.
// - Frames seven and eight are a record type; only zero is defined.
// - From frame nine, each pair of hex digits forms one data byte.
// - The last byte is a checksum; all bytes plus checksum must sum to zero.
// - A checksum error during duplicate shows error code E6.
// - A checksum error sounds a warbling tone while audio is enabled.
// - A compare mismatch stops and shows address and tape byte until enter.
// - Formats zero, two, four duplicate tape data into the buffer range.
// - Formats one, three, five compare tape data against the buffer range.
// - Format six stores record data at each record's load address.
// - Format seven compares record data at each record's load address.
// - With no format entered, format zero is used.
// - Ranged formats default to the whole buffer; operator may enter new limits.
// - While running, show direction digit, format code and an active mark.
// - On completion show interface and format, and accept a new format.
// - Four step lines go out; eight data lines and a sprocket come in.
// - In record format the address advances until the count is used, then read the checksum and seek a colon.
package thl_pkg;
   localparam logic [7:0] THL_CH_COLON    = 8'h3a;
   localparam logic [7:0] THL_CH_STAR     = 8'h2a;
   localparam logic [7:0] THL_CH_SLASH    = 8'h2f;
   localparam logic [7:0] THL_CH_DEL      = 8'hff;
   localparam logic [7:0] THL_CH_B        = 8'h42;
   localparam logic [7:0] THL_CH_N        = 8'h4e;
   localparam logic [7:0] THL_CH_P        = 8'h50;
   localparam logic [7:0] THL_CH_F        = 8'h46;
   localparam logic [7:0] THL_REC_TYPE_DATA = 8'h00;
   localparam logic [3:0] THL_FMT_DEFAULT = 4'h0;
   localparam logic [3:0] THL_FMT_REC_DUP = 4'h6;
   localparam logic [3:0] THL_FMT_REC_CMP = 4'h7;
   localparam logic [7:0] THL_ERR_CHECKSUM = 8'he6;
   localparam logic [3:0] THL_DIR_INPUT   = 4'h1;
   localparam logic [3:0] THL_DIR_OUTPUT  = 4'h0;
   localparam logic [3:0] THL_ACTIVE_CODE = 4'ha;
   // Stepping and tone timing
   localparam int THL_CLK_MHZ       = 250;
   localparam int THL_STEP_US       = 2000;
   localparam int THL_STEP_CYC      = THL_STEP_US * THL_CLK_MHZ;
   localparam int THL_WARBLE_US     = 1000;
   localparam int THL_WARBLE_CYC    = THL_WARBLE_US * THL_CLK_MHZ;
   localparam int THL_TONE_DIV      = 65536;

   typedef enum logic [3:0] {
      THL_ST_IDLE  = 4'b0000,
      THL_ST_STEP  = 4'b0001,
      THL_ST_WAIT  = 4'b0011,
      THL_ST_PARSE = 4'b0010,
      THL_ST_MEM   = 4'b0110,
      THL_ST_CHK   = 4'b0111,
      THL_ST_HALT  = 4'b0101,
      THL_ST_ERR   = 4'b0100,
      THL_ST_DONE  = 4'b1100
   } thl_state_t;

   typedef enum logic [2:0] {
      THL_RF_MARK = 3'b000,
      THL_RF_LEN  = 3'b001,
      THL_RF_ADDR = 3'b011,
      THL_RF_TYPE = 3'b010,
      THL_RF_DATA = 3'b110,
      THL_RF_SUM  = 3'b111
   } thl_rfield_t;

   typedef struct packed {
      logic [3:0] step;
      logic [7:0] data;
      logic       sprocket;
   } thl_reader_t;

   typedef struct packed {
      logic [3:0] digit_dir;
      logic [3:0] digit_fmt_hi;
      logic [3:0] digit_fmt_lo;
      logic [3:0] digit_active;
      logic [7:0] err_code;
      logic       active;
      logic       error;
   } thl_display_t;
endpackage

// ### thl_buffer_ram.sv
/*
 * Byte-wide buffer memory with one address shared by the write and the registered read.
 * Assumes a single synchronous clock; no reset on the array itself.
 */
`timescale 1ns/1ns
module thl_buffer_ram #(
   parameter int ADDR_W = 16,
   parameter int DATA_W = 8
) (
   input  wire logic              sys_clk,
   input  wire logic              we,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wdata,
   output logic      [DATA_W-1:0] rdata
);
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

   initial begin
      if (ADDR_W < 1 || ADDR_W > 16 || DATA_W < 1) begin
         $error("thl_buffer_ram: unsupported size");
      end
   end

   always_ff @(posedge sys_clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end
endmodule // thl_buffer_ram

// ### thl_loader.sv
/*
 * Paper-tape loader: steps the reader, parses hex, BNPF, binary and colon
 * records, and duplicates into or compares against the buffer memory.
 * Assumes front-panel inputs are synchronous one-cycle pulses or levels.
 */
`timescale 1ns/1ns
module thl_loader
   import thl_pkg::*;
#(
   parameter int ADDR_W     = 16,
   parameter int STEP_CYC   = thl_pkg::THL_STEP_CYC,
   parameter int WARBLE_CYC = thl_pkg::THL_WARBLE_CYC
) (
   input  wire logic                 sys_clk,
   input  wire logic                 rst,
   input  wire logic                 start,
   input  wire logic                 enter,
   input  wire logic                 fmt_valid,
   input  wire logic [3:0]           fmt_code,
   input  wire logic                 range_valid,
   input  wire logic [ADDR_W-1:0]    range_start,
   input  wire logic [ADDR_W-1:0]    range_end,
   input  wire logic                 audio_en,
   input  wire thl_pkg::thl_reader_t rdr_in,
   output logic      [3:0]           rdr_step,
   output thl_pkg::thl_display_t     disp,
   output logic      [ADDR_W-1:0]    disp_addr,
   output logic      [7:0]           disp_data,
   output logic                      tone,
   output logic                      busy
);
   import thl_pkg::*;

   initial begin
      if (ADDR_W < 4 || ADDR_W > 16 || STEP_CYC < 2 || WARBLE_CYC < 2) begin
         $error("thl_loader: unsupported parameter");
      end
   end

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   logic [8:0] rdr_meta_reg;
   logic [8:0] rdr_sync_reg;
   logic       spr_last_reg;
   logic       spr_rise;
   logic [7:0] tape_ch;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rdr_meta_reg <= '0;
         rdr_sync_reg <= '0;
         spr_last_reg <= 1'b0;
      end else begin
         rdr_meta_reg <= {rdr_in.sprocket, rdr_in.data};
         rdr_sync_reg <= rdr_meta_reg;
         spr_last_reg <= rdr_sync_reg[8];
      end
   end
   assign spr_rise = rdr_sync_reg[8] & ~spr_last_reg;
   assign tape_ch  = rdr_sync_reg[7:0];

   // Hex digit decode
   logic       ch_hex;
   logic [3:0] ch_nib;
   always_comb begin
      ch_hex = 1'b1;
      ch_nib = 4'h0;
      if (tape_ch >= 8'h30 && tape_ch <= 8'h39) begin
         ch_nib = tape_ch[3:0];
      end else if (tape_ch >= 8'h41 && tape_ch <= 8'h46) begin
         ch_nib = tape_ch[3:0] + 4'h9;
      end else begin
         ch_hex = 1'b0;
      end
   end

   // ************************************************************
   // Main sequencer
   // ************************************************************
   thl_state_t        st_reg,      st_next;
   thl_rfield_t       fld_reg,     fld_next;
   logic [3:0]        fmt_reg,     fmt_next;
   logic [ADDR_W-1:0] addr_reg,    addr_next;
   logic [ADDR_W-1:0] end_reg,     end_next;
   logic [ADDR_W-1:0] lim_s_reg,   lim_s_next;
   logic [ADDR_W-1:0] lim_e_reg,   lim_e_next;
   logic [15:0]       acc_reg,     acc_next;
   logic [2:0]        dig_reg,     dig_next;
   logic [7:0]        cnt_reg,     cnt_next;
   logic [7:0]        sum_reg,     sum_next;
   logic [7:0]        byte_reg,    byte_next;
   logic              started_reg, started_next;
   logic              wide_reg,    wide_next;
   logic [31:0]       tmr_reg,     tmr_next;
   logic [3:0]        phase_reg,   phase_next;
   logic [ADDR_W-1:0] daddr_reg,   daddr_next;
   logic [7:0]        ddata_reg,   ddata_next;
   logic              cksum_err_reg, cksum_err_next;
   logic              ram_we;
   logic [7:0]        ram_rd;

   logic       is_cmp;
   logic       is_rec;
   logic [7:0] new_byte;
   logic       range_end_hit;
   assign is_cmp   = fmt_reg[0];
   assign is_rec   = (fmt_reg == THL_FMT_REC_DUP) || (fmt_reg == THL_FMT_REC_CMP);
   assign new_byte = {acc_reg[3:0], ch_nib};
   assign range_end_hit = (addr_reg == end_reg);

   always_comb begin
      st_next = st_reg;        fld_next = fld_reg;    fmt_next = fmt_reg;
      addr_next = addr_reg;    end_next = end_reg;    lim_s_next = lim_s_reg;
      lim_e_next = lim_e_reg;  acc_next = acc_reg;    dig_next = dig_reg;
      cnt_next = cnt_reg;      sum_next = sum_reg;    byte_next = byte_reg;
      started_next = started_reg;  wide_next = wide_reg;
      tmr_next = tmr_reg;      phase_next = phase_reg;
      daddr_next = daddr_reg;  ddata_next = ddata_reg;
      cksum_err_next = cksum_err_reg;
      ram_we = 1'b0;
      case (st_reg)
         THL_ST_IDLE, THL_ST_DONE, THL_ST_ERR: begin
            if (fmt_valid) begin
               fmt_next = fmt_code;
            end
            if (range_valid) begin
               lim_s_next = range_start;
               lim_e_next = range_end;
            end
            if (start) begin
               addr_next = lim_s_reg;
               end_next = lim_e_reg;
               fld_next = THL_RF_MARK;
               started_next = is_rec;
               dig_next = 3'd0;
               wide_next = 1'b0;
               cksum_err_next = 1'b0;
               st_next = THL_ST_STEP;
            end
         end
         THL_ST_STEP: begin
            // One step pulse per character, then wait for its sprocket
            tmr_next = tmr_reg + 32'd1;
            if (tmr_reg == 32'(STEP_CYC - 1)) begin
               tmr_next = '0;
               phase_next = {phase_reg[2:0], phase_reg[3]};
               st_next = THL_ST_WAIT;
            end
         end
         THL_ST_WAIT: begin
            if (spr_rise) begin
               st_next = THL_ST_PARSE;
            end
         end
         THL_ST_PARSE: begin
            st_next = THL_ST_STEP;
            if (is_rec) begin
               if (tape_ch == THL_CH_COLON) begin
                  fld_next = THL_RF_LEN;
                  dig_next = 3'd0;
                  sum_next = 8'h00;
                  acc_next = '0;
               end else if (fld_reg != THL_RF_MARK && ch_hex) begin
                  acc_next = {acc_reg[11:0], ch_nib};
                  dig_next = dig_reg + 3'd1;
                  case (fld_reg)
                     THL_RF_LEN: if (dig_reg == 3'd1) begin
                        cnt_next = new_byte;
                        sum_next = sum_reg + new_byte;
                        dig_next = 3'd0;
                        fld_next = THL_RF_ADDR;
                     end
                     THL_RF_ADDR: if (dig_reg[0]) begin
                        sum_next = sum_reg + new_byte;
                        if (dig_reg == 3'd3) begin
                           addr_next = ADDR_W'({acc_reg[11:0], ch_nib});
                           dig_next = 3'd0;
                           fld_next = THL_RF_TYPE;
                        end
                     end
                     THL_RF_TYPE: if (dig_reg == 3'd1) begin
                        sum_next = sum_reg + new_byte;
                        dig_next = 3'd0;
                        // Non-zero types are carried but their bytes are not stored
                        wide_next = (new_byte != THL_REC_TYPE_DATA);
                        fld_next = (cnt_reg == 8'h00) ? THL_RF_SUM : THL_RF_DATA;
                     end
                     THL_RF_DATA: if (dig_reg == 3'd1) begin
                        sum_next = sum_reg + new_byte;
                        byte_next = new_byte;
                        dig_next = 3'd0;
                        cnt_next = cnt_reg - 8'h01;
                        if (!wide_reg) begin
                           st_next = THL_ST_MEM;
                        end else if (cnt_reg == 8'h01) begin
                           fld_next = THL_RF_SUM;
                        end
                     end
                     THL_RF_SUM: if (dig_reg == 3'd1) begin
                        sum_next = sum_reg + new_byte;
                        st_next = THL_ST_CHK;
                     end
                     default: fld_next = THL_RF_MARK;
                  endcase
               end
            end else begin
               case (fmt_reg[2:1])
                  2'b00: begin                                   // ASCII hex
                     if (!started_reg) begin
                        started_next = (tape_ch == THL_CH_STAR);
                     end else if (tape_ch == THL_CH_SLASH) begin
                        st_next = THL_ST_DONE;
                     end else if (ch_hex) begin
                        acc_next = {acc_reg[11:0], ch_nib};
                        dig_next = dig_reg + 3'd1;
                        if (dig_reg == 3'd1) begin
                           byte_next = new_byte;
                           dig_next = 3'd0;
                           st_next = THL_ST_MEM;
                        end
                     end else begin
                        dig_next = 3'd0;
                     end
                  end
                  2'b01: begin                                   // BNPF words
                     if (tape_ch == THL_CH_B) begin
                        wide_next = 1'b1;
                        dig_next = 3'd0;
                     end else if (wide_reg && (tape_ch == THL_CH_P || tape_ch == THL_CH_N)) begin
                        acc_next = {acc_reg[14:0], (tape_ch == THL_CH_P)};
                        dig_next = dig_reg + 3'd1;
                     end else if (wide_reg && tape_ch == THL_CH_F) begin
                        wide_next = 1'b0;
                        byte_next = acc_reg[7:0];
                        st_next = THL_ST_MEM;
                     end else begin
                        wide_next = 1'b0;
                     end
                  end
                  default: begin                                 // Binary
                     if (!started_reg) begin
                        started_next = (tape_ch == THL_CH_DEL);
                     end else begin
                        byte_next = tape_ch;
                        st_next = THL_ST_MEM;
                     end
                  end
               endcase
            end
         end
         THL_ST_MEM: begin
            // Read data is registered: compare one cycle after the address settles
            tmr_next = tmr_reg + 32'd1;
            if (!is_cmp) begin
               ram_we = 1'b1;
            end
            if (is_cmp && tmr_reg == 32'd0) begin
               st_next = THL_ST_MEM;
            end else begin
               tmr_next = '0;
               st_next = THL_ST_STEP;
               if (is_cmp && ram_rd != byte_reg) begin
                  daddr_next = addr_reg;
                  ddata_next = byte_reg;
                  st_next = THL_ST_HALT;
               end
               addr_next = addr_reg + ADDR_W'(1);
               if (is_rec) begin
                  if (cnt_reg == 8'h00) begin
                     fld_next = THL_RF_SUM;
                  end
               end else if (range_end_hit) begin
                  st_next = (st_next == THL_ST_HALT) ? THL_ST_HALT : THL_ST_DONE;
                  end_next = addr_reg;
                  started_next = 1'b0;
               end
            end
         end
         THL_ST_HALT: begin
            if (enter) begin
               st_next = (!is_rec && !started_reg) ? THL_ST_DONE : THL_ST_STEP;
            end
         end
         THL_ST_CHK: begin
            fld_next = THL_RF_MARK;
            st_next = THL_ST_STEP;
            if (sum_reg != 8'h00) begin
               cksum_err_next = 1'b1;
               if (!is_cmp) begin
                  st_next = THL_ST_ERR;
               end
            end
         end
         default: st_next = THL_ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_reg <= THL_ST_IDLE;       fld_reg <= THL_RF_MARK;
         fmt_reg <= THL_FMT_DEFAULT;
         addr_reg <= '0;              end_reg <= '0;
         lim_s_reg <= '0;
         lim_e_reg <= '1;
         acc_reg <= '0;  dig_reg <= '0;  cnt_reg <= '0;  sum_reg <= '0;
         byte_reg <= '0; started_reg <= 1'b0; wide_reg <= 1'b0;
         tmr_reg <= '0;  phase_reg <= 4'h1;
         daddr_reg <= '0; ddata_reg <= '0; cksum_err_reg <= 1'b0;
      end else begin
         st_reg <= st_next;           fld_reg <= fld_next;
         fmt_reg <= fmt_next;
         addr_reg <= addr_next;       end_reg <= end_next;
         lim_s_reg <= lim_s_next;     lim_e_reg <= lim_e_next;
         acc_reg <= acc_next;  dig_reg <= dig_next;  cnt_reg <= cnt_next;
         sum_reg <= sum_next;
         byte_reg <= byte_next; started_reg <= started_next; wide_reg <= wide_next;
         tmr_reg <= tmr_next;  phase_reg <= phase_next;
         daddr_reg <= daddr_next; ddata_reg <= ddata_next;
         cksum_err_reg <= cksum_err_next;
      end
   end

   thl_buffer_ram #(
      .ADDR_W (ADDR_W),
      .DATA_W (8)
   ) u_ram (
      .sys_clk (sys_clk),
      .we      (ram_we),
      .addr    (addr_reg),
      .wdata   (byte_reg),
      .rdata   (ram_rd)
   );

   // ************************************************************
   // Warble tone and registered outputs
   // ************************************************************
   logic [31:0]  wtmr_reg, wtmr_next;
   logic [15:0]  tdiv_reg, tdiv_next;
   logic         tone_next;
   logic         tone_reg;
   thl_display_t disp_next;
   thl_display_t disp_reg;

   always_comb begin
      wtmr_next = wtmr_reg + 32'd1;
      if (wtmr_reg == 32'(WARBLE_CYC - 1)) begin
         wtmr_next = '0;
      end
      // Two pitches alternate each half warble period
      tdiv_next = tdiv_reg + (wtmr_reg < 32'(WARBLE_CYC / 2) ? 16'd2 : 16'd3);
      tone_next = audio_en & cksum_err_reg & tdiv_reg[15];
      disp_next = '0;
      disp_next.digit_fmt_hi = 4'h0;
      disp_next.digit_fmt_lo = fmt_reg;
      disp_next.active = (st_reg != THL_ST_IDLE) && (st_reg != THL_ST_DONE)
                         && (st_reg != THL_ST_ERR);
      if (disp_next.active) begin
         disp_next.digit_dir = is_cmp ? THL_DIR_OUTPUT : THL_DIR_INPUT;
         disp_next.digit_active = THL_ACTIVE_CODE;
      end
      if (st_reg == THL_ST_ERR) begin
         disp_next.err_code = THL_ERR_CHECKSUM;
         disp_next.error = 1'b1;
      end
      if (st_reg == THL_ST_HALT) begin
         disp_next.error = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wtmr_reg  <= '0;
         tdiv_reg  <= '0;
         tone_reg  <= 1'b0;
         disp_reg  <= '0;
         rdr_step  <= 4'h0;
         disp_addr <= '0;
         disp_data <= '0;
         busy      <= 1'b0;
      end else begin
         wtmr_reg  <= wtmr_next;
         tdiv_reg  <= tdiv_next;
         tone_reg  <= tone_next;
         disp_reg  <= disp_next;
         rdr_step  <= (st_reg == THL_ST_IDLE) ? 4'h0 : phase_reg;
         disp_addr <= daddr_reg;
         disp_data <= ddata_reg;
         busy      <= disp_next.active;
      end
   end
   assign tone = tone_reg;
   assign disp = disp_reg;
endmodule // thl_loader

// ### thl_loader_monitor.sv
/* Port checker for thl_loader, attached by the bind at the foot.
   Assumes one clock domain and rst active high. */
`timescale 1ns/1ns
module thl_loader_monitor
   import thl_pkg::*;
#(parameter int ADDR_W = 16) (
   input wire logic                  sys_clk,
   input wire logic                  rst,
   input wire logic                  start,
   input wire logic                  enter,
   input wire logic                  fmt_valid,
   input wire logic [3:0]            fmt_code,
   input wire logic                  range_valid,
   input wire logic [ADDR_W-1:0]     range_start,
   input wire logic [ADDR_W-1:0]     range_end,
   input wire logic                  audio_en,
   input wire thl_pkg::thl_reader_t  rdr_in,
   input wire logic [3:0]            rdr_step,
   input wire thl_pkg::thl_display_t disp,
   input wire logic [ADDR_W-1:0]     disp_addr,
   input wire logic [7:0]            disp_data,
   input wire logic                  tone,
   input wire logic                  busy
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   property p_start_busy; !busy && start |-> ##2 busy; endproperty
   a_start_busy: assert property (p_start_busy) else $error("start not taken");
   property p_active_mark; disp.active |-> disp.digit_active == 4'ha && disp.digit_fmt_hi == 4'h0; endproperty
   a_active_mark: assert property (p_active_mark) else $error("bad active digits");
   property p_dir_digit; disp.active |-> disp.digit_dir == {3'b000, ~disp.digit_fmt_lo[0]}; endproperty
   a_dir_digit: assert property (p_dir_digit) else $error("bad direction");
   property p_active_busy; disp.active |-> busy; endproperty
   a_active_busy: assert property (p_active_busy) else $error("active while idle");
   property p_err_code; disp.err_code != 8'h00 |-> disp.err_code == 8'he6; endproperty
   a_err_code: assert property (p_err_code) else $error("bad error code");
   property p_tone_audio; $rose(tone) |-> $past(audio_en); endproperty
   a_tone_audio: assert property (p_tone_audio) else $error("tone without audio");
   property p_step_onehot; rdr_step != 4'h0 |-> $onehot(rdr_step); endproperty
   a_step_onehot: assert property (p_step_onehot) else $error("step not one-hot");
   property p_step_hold; $changed(rdr_step) && rdr_step != 4'h0 |=> $stable(rdr_step) [*3]; endproperty
   a_step_hold: assert property (p_step_hold) else $error("stepped too soon");
endmodule // thl_loader_monitor

bind thl_loader thl_loader_monitor #(.ADDR_W(ADDR_W)) u_thl_loader_monitor (
   .sys_clk(sys_clk), .rst(rst), .start(start), .enter(enter), .fmt_valid(fmt_valid),
   .fmt_code(fmt_code), .range_valid(range_valid), .range_start(range_start),
   .range_end(range_end), .audio_en(audio_en), .rdr_in(rdr_in), .rdr_step(rdr_step),
   .disp(disp), .disp_addr(disp_addr), .disp_data(disp_data), .tone(tone), .busy(busy));

// ### thl_reader_model.sv
/* Behavioural paper tape reader: one character per step phase.
   Assumes the loader waits for each sprocket before stepping again. */
`timescale 1ns/1ns
module thl_reader_model
   import thl_pkg::*;
(
   input  wire logic                 sys_clk,
   input  wire logic [3:0]           rdr_step,
   output thl_pkg::thl_reader_t      rdr
);
   logic [7:0] tape[$];
   logic [3:0] last;
   task automatic load(input string s);
      tape.delete();
      foreach (s[i]) tape.push_back(s[i]);
   endtask
   initial begin
      rdr = '0;
      last = 4'h0;
      forever begin
         @(posedge sys_clk);
         #1;
         // Energising a phase from rest moves no tape; only a phase change does
         if (rdr_step !== last && rdr_step !== 4'h0 && last !== 4'h0
             && tape.size() > 0) begin
            last = rdr_step;
            repeat (2) @(posedge sys_clk);
            #1 rdr.data = tape.pop_front();
            rdr.sprocket = 1'b1;
            repeat (4) @(posedge sys_clk);
            #1 rdr.sprocket = 1'b0;
            repeat (2) @(posedge sys_clk);
            // Hold over: stale data must not look valid
            #1 rdr.data = ~rdr.data;
         end else begin
            last = rdr_step;
         end
      end
   end
endmodule // thl_reader_model

// ### tape_hex_record_loader_test.sv
/* Self-checking bench for thl_loader with the reader model.
   Assumes short step and tone counts set at the instance. */
`timescale 1ns/1ns
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
   $display("mismatch at %0t: got %h expected %h", $time, a, b); end end
`define WAITC(c, n) for (int k = 0; k < (n) && !(c); k++) tick(1);
module tape_hex_record_loader_test;
   import thl_pkg::*;
   logic         sys_clk, rst, start, enter, fmt_valid, range_valid, audio_en, tone, busy;
   logic [3:0]   fmt_code, rdr_step;
   logic [15:0]  range_start, range_end, disp_addr;
   logic [7:0]   disp_data;
   thl_reader_t  rdr_in;
   thl_display_t disp;
   int           err_count = 0;
   int           checks_done = 0;
   thl_loader #(.ADDR_W(16), .STEP_CYC(4), .WARBLE_CYC(16)) u_thl_loader (
      .sys_clk(sys_clk), .rst(rst), .start(start), .enter(enter), .fmt_valid(fmt_valid),
      .fmt_code(fmt_code), .range_valid(range_valid), .range_start(range_start),
      .range_end(range_end), .audio_en(audio_en), .rdr_in(rdr_in), .rdr_step(rdr_step),
      .disp(disp), .disp_addr(disp_addr), .disp_data(disp_data), .tone(tone), .busy(busy));
   thl_reader_model u_thl_reader_model (.sys_clk(sys_clk),
      .rdr_step(rdr_step), .rdr(rdr_in));
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic reset_dut;
      rst = 1'b1;
      tick(2);
      rst = 1'b0;
      tick(1);
   endtask
   task automatic run(input logic [3:0] f, input bit setf, input logic [15:0] e, input string t);
      u_thl_reader_model.load(t);
      if (setf) begin
         fmt_code = f;
         fmt_valid = 1'b1;
         tick(1);
         fmt_valid = 1'b0;
      end
      range_start = 16'h0000;
      range_end = e;
      range_valid = 1'b1;
      tick(1);
      range_valid = 1'b0;
      start = 1'b1;
      tick(1);
      start = 1'b0;
      tick(3);
      `CHK(disp.active, 1'b1)
      `CHK(disp.digit_dir, {3'b000, ~f[0]})
      `CHK(disp.digit_fmt_lo, f)
   endtask
   // Default format, then a compare that halts on the third byte
   task automatic t_ranged;
      run(4'h0, 1'b0, 16'h0003, "hdr*1234 5678");
      `WAITC(busy === 1'b0, 2000)
      `CHK({busy, disp.active, disp.digit_fmt_lo}, 6'h00)
      run(4'h1, 1'b1, 16'h0003, "*1234FF78");
      `WAITC(disp_data === 8'hff, 2000)
      `CHK(disp_addr, 16'h0002)
      tick(40);
      `CHK({busy, disp_data}, 9'h1ff)
      enter = 1'b1;
      tick(1);
      enter = 1'b0;
      `WAITC(busy === 1'b0, 2000)
      `CHK(busy, 1'b0)
   endtask
   // Record load, then a record compare off by one in the second byte
   task automatic t_record;
      reset_dut();
      run(4'h6, 1'b1, 16'h0000, "x:02001000ABCD76");
      `WAITC(u_thl_reader_model.tape.size() == 0, 2000)
      tick(40);
      `CHK({busy, disp.error}, 2'b10)
      reset_dut();
      run(4'h7, 1'b1, 16'h0000, ":02001000ABCE75");
      `WAITC(disp_data === 8'hce, 2000)
      `CHK(disp_addr, 16'h0011)
   endtask
   // Bad checksum: code shown, tone only once audio is enabled
   task automatic t_cksum;
      reset_dut();
      audio_en = 1'b0;
      run(4'h6, 1'b1, 16'h0000, ":01002000558B");
      `WAITC(disp.error === 1'b1, 2000)
      `CHK(disp.err_code, 8'he6)
      tick(100);
      `CHK(tone, 1'b0)
      audio_en = 1'b1;
      `WAITC(tone === 1'b1, 70000)
      `CHK(tone, 1'b1)
   endtask
   // Binary load, then a BNPF compare that halts on the end address
   task automatic t_words;
      run(4'h4, 1'b1, 16'h0001, "\377AB");
      `WAITC(busy === 1'b0, 2000)
      run(4'h3, 1'b1, 16'h0001, "BNPNNNNNPFxBNPNNNNPPF");
      `WAITC(disp_data === 8'h43, 2000)
      `CHK({disp_addr, disp_data}, 24'h000143)
      enter = 1'b1;
      tick(1);
      enter = 1'b0;
      `WAITC(busy === 1'b0, 2000)
      `CHK({busy, disp.error}, 2'b00)
   endtask
   initial begin
      {rst, start, enter, fmt_valid, range_valid, audio_en} = 6'b100000;
      {fmt_code, range_start, range_end} = '0;
      tick(5);
      rst = 1'b0;
      tick(1);
      t_ranged();
      t_record();
      t_cksum();
      t_words();
      conclude();
   end
   initial begin
      repeat (95000) @(posedge sys_clk);
      err_count++;
      conclude();
   end
endmodule // tape_hex_record_loader_test
